// ---- dvr_pkg.sv ----
// constants, field layouts and state carrier for the dac volume register bank
// assumes a single 100 MHz clock domain shared by every user of the package
package dvr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // control word layout
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int ATTEN_W = 8;
  localparam int UPDATE_BIT = 8;
  localparam int NUM_CH = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [6:0] ADDR_CH1_LEFT = 7'h00;
  localparam logic [6:0] ADDR_CH1_RIGHT = 7'h01;
  localparam logic [6:0] ADDR_MIX_MUTE = 7'h02;
  localparam logic [6:0] ADDR_AUDIO_FMT = 7'h03;
  localparam logic [6:0] ADDR_CH2_LEFT = 7'h04;
  localparam logic [6:0] ADDR_CH2_RIGHT = 7'h05;
  localparam logic [6:0] ADDR_CH3_LEFT = 7'h06;
  localparam logic [6:0] ADDR_CH3_RIGHT = 7'h07;
  localparam logic [6:0] ADDR_ALL_CH = 7'h08;
  localparam logic [6:0] ADDR_DEEMPH_MUTE = 7'h09;
  localparam logic [6:0] ADDR_RATE_PWR = 7'h0a;
  localparam logic [6:0] ADDR_MUTE_PIN = 7'h0c;
  localparam logic [6:0] ADDR_CH4_LEFT = 7'h0d;
  localparam logic [6:0] ADDR_CH4_RIGHT = 7'h0e;
  localparam logic [6:0] ADDR_CH4_CTRL = 7'h0f;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] ATTEN_DEFAULT = 8'hff;
  localparam logic [7:0] ATTEN_MUTE_CODE = 8'h00;
  localparam logic [8:0] MIX_MUTE_RESET = 9'h120;
  localparam logic [8:0] AUDIO_FMT_RESET = 9'h000;
  localparam logic [8:0] DEEMPH_MUTE_RESET = 9'h000;
  localparam logic [8:0] RATE_PWR_RESET = 9'h080;
  localparam logic [8:0] MUTE_PIN_RESET = 9'h000;
  localparam logic [8:0] CH4_CTRL_RESET = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  // timing: software reset holds for this many reference clock periods
  localparam logic [1:0] SOFT_RESET_CYCLES = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [ATTEN_W-1:0] dvr_atten_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dvr_word_t;

  typedef struct packed {
    logic [8:0] mix_mute;
    logic [8:0] audio_fmt;
    logic [8:0] deemph_mute;
    logic [8:0] rate_pwr;
    logic [8:0] mute_pin;
    logic [8:0] ch4_ctrl;
  } dvr_misc_t;

  typedef struct packed {
    dvr_atten_t [NUM_CH-1:0] pend;
    dvr_atten_t [NUM_CH-1:0] act;
    logic [NUM_CH-1:0] mute;
    dvr_misc_t misc;
    logic soft_rst;
    logic [1:0] soft_cnt;
    logic [2:0] run_sync;
    logic run;
  } dvr_state_t;

endpackage

// ---- dvr_volume_bank.sv ----
// register bank of an eight channel dac: double-buffered attenuation,
// master attenuation, soft reset and the remaining control registers
// assumes control words arrive already deserialised on the reference clock;
// master clock presence arrives as an asynchronous level on a pin
`timescale 1ns/10ps
`default_nettype none

module dvr_volume_bank
  import dvr_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // control word from the serial receiver
  input wire logic CTRL_WR_I,
  input wire logic [WORD_W-1:0] CTRL_WORD_I,
  // master clock presence pin
  input wire logic MCLK_RUN_I,
  // attenuation applied to the outputs
  output logic [CHANNELS*ATTEN_W-1:0] ACTIVE_ATTEN_O,
  output logic [CHANNELS*ATTEN_W-1:0] PENDING_ATTEN_O,
  output logic [CHANNELS-1:0] CH_MUTE_O,
  // other control registers
  output logic [DATA_W-1:0] MIX_MUTE_O,
  output logic [DATA_W-1:0] AUDIO_FMT_O,
  output logic [DATA_W-1:0] DEEMPH_MUTE_O,
  output logic [DATA_W-1:0] RATE_PWR_O,
  output logic [DATA_W-1:0] MUTE_PIN_O,
  output logic [DATA_W-1:0] CH4_CTRL_O,
  // status
  output logic SOFT_RESET_O,
  output logic MCLK_RUN_O
);

  ////////////////////////////////////////////////////////////////////////////
  // reset image of the whole state

  function automatic dvr_state_t reset_image();
    dvr_state_t r;
    r = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      r.pend[i] = ATTEN_DEFAULT;
      r.act[i] = ATTEN_DEFAULT;
    end
    r.misc.mix_mute = MIX_MUTE_RESET;
    r.misc.audio_fmt = AUDIO_FMT_RESET;
    r.misc.deemph_mute = DEEMPH_MUTE_RESET;
    r.misc.rate_pwr = RATE_PWR_RESET;
    r.misc.mute_pin = MUTE_PIN_RESET;
    r.misc.ch4_ctrl = CH4_CTRL_RESET;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  dvr_state_t s;
  dvr_state_t next_s;
  dvr_word_t word;
  dvr_state_t defaults;
  logic ch_hit;
  logic [2:0] ch_idx;

  assign word = CTRL_WORD_I;
  assign defaults = reset_image();

  // address to channel slot: left/right pairs in order ch1..ch4
  always_comb begin
    ch_hit = 1'b1;
    ch_idx = 3'h0;
    if (word.addr == ADDR_CH1_LEFT) begin
      ch_idx = 3'h0;
    end else if (word.addr == ADDR_CH1_RIGHT) begin
      ch_idx = 3'h1;
    end else if (word.addr == ADDR_CH2_LEFT) begin
      ch_idx = 3'h2;
    end else if (word.addr == ADDR_CH2_RIGHT) begin
      ch_idx = 3'h3;
    end else if (word.addr == ADDR_CH3_LEFT) begin
      ch_idx = 3'h4;
    end else if (word.addr == ADDR_CH3_RIGHT) begin
      ch_idx = 3'h5;
    end else if (word.addr == ADDR_CH4_LEFT) begin
      ch_idx = 3'h6;
    end else if (word.addr == ADDR_CH4_RIGHT) begin
      ch_idx = 3'h7;
    end else begin
      ch_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    // first stage feeds only the shift; the run level moves when stages two and three agree
    next_s.run_sync = {s.run_sync[1:0], MCLK_RUN_I};
    if (s.run_sync[1] == s.run_sync[2]) begin
      next_s.run = s.run_sync[2];
    end

    // soft reset timeout
    if (s.soft_rst) begin
      if (s.soft_cnt <= 2'h1) begin
        next_s.soft_rst = 1'b0;
        next_s.soft_cnt = 2'h0;
      end else begin
        next_s.soft_cnt = s.soft_cnt - 2'h1;
      end
    end

    if (CTRL_WR_I) begin
      // any write other than a soft reset ends a running soft reset and is itself applied; a soft reset write restarts it
      next_s.soft_rst = 1'b0;
      next_s.soft_cnt = 2'h0;
      if (word.addr == ADDR_SOFT_RESET) begin
        next_s.pend = defaults.pend;
        next_s.act = defaults.act;
        next_s.misc = defaults.misc;
        next_s.soft_rst = 1'b1;
        next_s.soft_cnt = SOFT_RESET_CYCLES;
      end else if (ch_hit) begin
        next_s.pend[ch_idx] = word.data[ATTEN_W-1:0];
      end else if (word.addr == ADDR_ALL_CH) begin
        for (int i = 0; i < NUM_CH; i++) begin
          next_s.pend[i] = word.data[ATTEN_W-1:0];
        end
      end else if (word.addr == ADDR_MIX_MUTE) begin
        next_s.misc.mix_mute = word.data;
      end else if (word.addr == ADDR_AUDIO_FMT) begin
        next_s.misc.audio_fmt = word.data;
      end else if (word.addr == ADDR_DEEMPH_MUTE) begin
        next_s.misc.deemph_mute = word.data;
      end else if (word.addr == ADDR_RATE_PWR) begin
        next_s.misc.rate_pwr = word.data;
      end else if (word.addr == ADDR_MUTE_PIN) begin
        next_s.misc.mute_pin = word.data;
      end else if (word.addr == ADDR_CH4_CTRL) begin
        next_s.misc.ch4_ctrl = word.data;
      end
      // update flag carries every latch across in the same edge, including this write
      if ((ch_hit || word.addr == ADDR_ALL_CH) && word.data[UPDATE_BIT]) begin
        next_s.act = next_s.pend;
      end
    end

    // no master clock: volume falls back to 0 dB; host must rewrite afterwards
    if (!s.run) begin
      next_s.pend = defaults.pend;
      next_s.act = defaults.act;
    end

    for (int i = 0; i < NUM_CH; i++) begin
      next_s.mute[i] = (next_s.act[i] == ATTEN_MUTE_CODE);
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      s <= reset_image();
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all taken from the state register

  assign ACTIVE_ATTEN_O = s.act;
  assign PENDING_ATTEN_O = s.pend;
  assign CH_MUTE_O = s.mute;
  assign MIX_MUTE_O = s.misc.mix_mute;
  assign AUDIO_FMT_O = s.misc.audio_fmt;
  assign DEEMPH_MUTE_O = s.misc.deemph_mute;
  assign RATE_PWR_O = s.misc.rate_pwr;
  assign MUTE_PIN_O = s.misc.mute_pin;
  assign CH4_CTRL_O = s.misc.ch4_ctrl;
  assign SOFT_RESET_O = s.soft_rst;
  assign MCLK_RUN_O = s.run;

endmodule

`default_nettype wire

// ---- dvr_host.sv ----
// host model: sends control words to the bank
// assumes calls are made just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module dvr_host
  import dvr_pkg::*;
(
  // clock
  input wire logic clk_i,
  // control word
  output logic wr_o,
  output logic [WORD_W-1:0] word_o
);
  bit held = 1'b0;
  initial begin
    wr_o = 1'b0;
    word_o = 16'h0000;
  end
  // last low keeps the strobe up for a back to back word
  task automatic send(input logic [6:0] a, input logic [8:0] d, input bit last);
    if (!held) begin
      @(posedge clk_i);
      #1;
    end
    wr_o = 1'b1;
    word_o = {a, d};
    @(posedge clk_i);
    #1;
    held = !last;
    if (last) begin
      wr_o = 1'b0;
      word_o = ~word_o; // no stale word after release
    end
  endtask
endmodule
`default_nettype wire

// ---- dvr_volume_bank_chk.sv ----
// checker on the bank ports
// assumes one clock and a synchronous reset
`timescale 1ns/10ps
`default_nettype none
module dvr_volume_bank_chk
  import dvr_pkg::*;
#(parameter int CHANNELS = NUM_CH) (
  // clock, reset, write port
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic CTRL_WR_I,
  input wire logic [WORD_W-1:0] CTRL_WORD_I,
  // outputs
  input wire logic [CHANNELS*ATTEN_W-1:0] ACTIVE_ATTEN_O,
  input wire logic [CHANNELS*ATTEN_W-1:0] PENDING_ATTEN_O,
  input wire logic [CHANNELS-1:0] CH_MUTE_O,
  input wire logic SOFT_RESET_O,
  input wire logic MCLK_RUN_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  logic [6:0] a;
  logic sw;
  logic w;
  logic atn;
  assign a = CTRL_WORD_I[15:9];
  // only the attenuation registers honour the update flag
  assign atn = w && ((a <= ADDR_ALL_CH && a != ADDR_MIX_MUTE && a != ADDR_AUDIO_FMT)
    || a == ADDR_CH4_LEFT || a == ADDR_CH4_RIGHT);
  assign sw = CTRL_WR_I && a != ADDR_SOFT_RESET;
  // attenuation writes while the clock is lost are overridden
  assign w = sw && MCLK_RUN_O;
  //////////////////////////////
  AST_HOLD: assert property (
    w && !CTRL_WORD_I[8] |=> $stable(ACTIVE_ATTEN_O)) else $error("active moved");
  AST_UPD: assert property (
    atn && CTRL_WORD_I[8] |=> ACTIVE_ATTEN_O == PENDING_ATTEN_O) else $error("no update");
  AST_MAST: assert property (
    w && a == ADDR_ALL_CH |=> PENDING_ATTEN_O == {CHANNELS{$past(CTRL_WORD_I[7:0])}}) else $error("master load");
  AST_MUTE: assert property (
    CH_MUTE_O[0] == (ACTIVE_ATTEN_O[7:0] == 8'h00) && CH_MUTE_O[7] == (ACTIVE_ATTEN_O[63:56] == 8'h00))
    else $error("mute flag");
  AST_LOSS: assert property (
    !MCLK_RUN_O |=> ACTIVE_ATTEN_O == {CHANNELS{8'hff}}) else $error("volume kept");
  AST_SRST: assert property (
    CTRL_WR_I && !sw |=> SOFT_RESET_O && PENDING_ATTEN_O == {CHANNELS{8'hff}}) else $error("soft reset");
  AST_SLEN: assert property (
    $rose(SOFT_RESET_O) && !CTRL_WR_I |=> SOFT_RESET_O ##1 (!SOFT_RESET_O || $past(CTRL_WR_I)))
    else $error("soft length");
  AST_SEND: assert property (
    SOFT_RESET_O && sw |=> !SOFT_RESET_O) else $error("soft not ended");
  cover property (atn && CTRL_WORD_I[8]);
  cover property ($fell(MCLK_RUN_O));
  cover property ($rose(SOFT_RESET_O));
endmodule
bind dvr_volume_bank dvr_volume_bank_chk #(.CHANNELS(CHANNELS)) chk (.REF_CLK_I(REF_CLK_I),
  .NRST_I(NRST_I), .CTRL_WR_I(CTRL_WR_I), .CTRL_WORD_I(CTRL_WORD_I), .ACTIVE_ATTEN_O(ACTIVE_ATTEN_O),
  .PENDING_ATTEN_O(PENDING_ATTEN_O), .CH_MUTE_O(CH_MUTE_O), .SOFT_RESET_O(SOFT_RESET_O),
  .MCLK_RUN_O(MCLK_RUN_O));
`default_nettype wire

// ---- tb.sv ----
// bench: host model drives the bank
// assumes the checker binds itself
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dvr_pkg::*;
  logic clk, nrst, run, wr, srst, mrun;
  logic [15:0] word;
  logic [63:0] act, pend, ep;
  logic [7:0] mute;
  logic [8:0] mix, fmt, dm, rp, mp, c4;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [6:0] ca [8] = '{7'h00, 7'h01, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0d, 7'h0e};
  localparam logic [63:0] FF = {8{8'hff}};
  dvr_host host (.clk_i(clk), .wr_o(wr), .word_o(word));
  dvr_volume_bank uut (.REF_CLK_I(clk), .NRST_I(nrst), .CTRL_WR_I(wr), .CTRL_WORD_I(word),
    .MCLK_RUN_I(run), .ACTIVE_ATTEN_O(act), .PENDING_ATTEN_O(pend), .CH_MUTE_O(mute),
    .MIX_MUTE_O(mix), .AUDIO_FMT_O(fmt), .DEEMPH_MUTE_O(dm), .RATE_PWR_O(rp), .MUTE_PIN_O(mp),
    .CH4_CTRL_O(c4), .SOFT_RESET_O(srst), .MCLK_RUN_O(mrun));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic t_latch();
    ep = FF;
    for (int i = 0; i < 8; i++) begin
      ep[8*i+:8] = 8'h11 * i[7:0] + 8'h01;
      host.send(ca[i], {i == 7, ep[8*i+:8]}, 1'b1);
      chk(pend, ep);
      chk(act, i == 7 ? ep : FF);
    end
  endtask
  task automatic t_master();
    host.send(7'h08, 9'h000, 1'b1);
    chk({pend, act}, {64'h0, ep});
    host.send(7'h00, 9'h100, 1'b1);
    chk({act, mute}, {64'h0, 8'hff});
    host.send(7'h08, 9'h1fe, 1'b1);
    chk({act, mute}, {{8{8'hfe}}, 8'h00});
  endtask
  task automatic t_loss();
    run = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    host.send(7'h08, 9'h140, 1'b1);
    chk({mrun, act, pend}, {1'b0, FF, FF});
    run = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    host.send(7'h08, 9'h140, 1'b1);
    chk(act, {8{8'h40}});
  endtask
  task automatic t_soft();
    host.send(7'h02, 9'h0aa, 1'b1);
    chk(mix, 9'h0aa);
    host.send(7'h09, 9'h1ff, 1'b1);
    host.send(7'h0a, 9'h1fe, 1'b1);
    host.send(7'h0c, 9'h040, 1'b1);
    host.send(7'h0f, 9'h03f, 1'b1);
    chk({dm, rp, mp, c4}, {9'h1ff, 9'h1fe, 9'h040, 9'h03f});
    host.send(7'h1f, 9'h000, 1'b0);
    chk({srst, mix, act, dm, rp, mp, c4}, {1'b1, 9'h120, FF, 9'h000, 9'h080, 9'h000, 9'h000});
    host.send(7'h03, 9'h005, 1'b1);
    chk({srst, fmt}, {1'b0, 9'h005});
    host.send(7'h1f, 9'h000, 1'b1);
    for (int i = 0; i < 3; i++) begin
      chk(srst, i < 2);
      @(posedge clk);
      #1;
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    run = 1'b1;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({act, pend, mute}, {FF, FF, 8'h00});
    t_latch();
    t_master();
    t_loss();
    t_soft();
    test_done();
  end
endmodule
`default_nettype wire
